// ---- design/phy_pm_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts of the
//          power and test control block
// Assumes: word index times four gives the byte address on the bus
// Notes:   all registers are 16 bits wide, upper half of the bus word reads zero
`ifndef PHY_PM_MAP_SVH
`define PHY_PM_MAP_SVH

// ----------------------------------------------------------------------
// register indices
// ----------------------------------------------------------------------
`define IDX_BASIC_CTRL    5'h00
`define IDX_CTRL_PLL      5'h10
`define IDX_CTRL_OSC      5'h11
`define IDX_CTRL_TEST     5'h16
`define IDX_CTRL_ENERGY_DETECT_POWERDOWN     5'h18
`define IDX_POWER_STATUS  5'h19
`define IDX_DIAG          5'h1D
`define IDX_CTRL2         5'h1F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BC_SWRESET_BIT    15
`define BC_ANEN_BIT       12
`define BC_PWRDN_BIT      11
`define PLL_AUTO_OFF_BIT  4
`define OSC_SLOW_BIT      5
`define TEST_NAND_BIT     5
`define ENERGY_DETECT_POWERDOWN_EN_N_BIT     11
`define DIAG_START_BIT    15
`define DIAG_RESULT_W     9
`define C2_MDIX_SEL_BIT   14
`define C2_MDIX_DIS_BIT   13
`define C2_PSAVE_BIT      10

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_BASIC_CTRL    16'h1000
`define RST_CTRL_PLL      16'h0000
`define RST_CTRL_OSC      16'h0000
`define RST_CTRL_TEST     16'h0000
`define RST_CTRL_ENERGY_DETECT_POWERDOWN     16'h0800
`define RST_CTRL2         16'h0000

// ----------------------------------------------------------------------
// timing and nand tree length
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS     4
`define LINK_PULSE_US     16
`define NAND_TREE_INPUTS  11

`endif

// ---- design/phy_pm_pkg.sv ----
// Purpose: types shared by the power and test control block
// Assumes: nothing beyond the map header
// Notes:   numbers live in the map header, only types here
package phy_pm_pkg;
   typedef enum logic [0:0] {
      DIAG_IDLE,
      DIAG_RUN
   } diag_state_t;

   typedef logic [15:0] reg16_t;
endpackage

// ---- design/nand_tree_if.sv ----
// Purpose: carries the nand tree pin levels and chain result between modules
// Assumes: pin levels are raw, unclocked
// Notes:   bit 0 is the first pin of the test order
`timescale 1ns/1ps
`include "phy_pm_map.svh"
interface nand_tree_if;
   logic [`NAND_TREE_INPUTS-1:0] pin_level;
   logic                         chain_out;
   modport src  (output pin_level, input  chain_out);
   modport tree (input  pin_level, output chain_out);
endinterface

// ---- design/nand_tree_chain.sv ----
// Purpose: nested nand chain for board-level pin connectivity test
// Assumes: order is mdio, mdc, rxd1, rxd0, crs_dv, ref_clk, interrupt pin,
//          txen, indicator 1, indicator 0, txd0
// Notes:   purely combinational so it works with the clock pin used as input
`timescale 1ns/1ps
`include "phy_pm_map.svh"
module nand_tree_chain #(
   parameter bit rmii_variant = 1'b1
) (
   nand_tree_if.tree nt
);
   import phy_pm_pkg::*;

   logic [`NAND_TREE_INPUTS-1:0] stage;
   logic [`NAND_TREE_INPUTS-1:0] pin_eff;

   // the mii variant has no indicator 1 pin: its stage sees a constant high
   always_comb begin
      pin_eff    = nt.pin_level;
      pin_eff[8] = rmii_variant ? nt.pin_level[8] : 1'b1;
   end

   always_comb begin
      stage[0] = ~pin_eff[0];
      for (int k = 1; k < `NAND_TREE_INPUTS; k++) begin
         stage[k] = ~(stage[k-1] & pin_eff[k]);
      end
   end

   // odd chain length: invert so all-high gives a high output, first low falls
   assign nt.chain_out = ~stage[`NAND_TREE_INPUTS-1];
endmodule // nand_tree_chain

// ---- design/phy_pm_ctrl.sv ----
// Purpose: power modes, nand tree test and cable diagnostic start of a phy
// Assumes: link and diag inputs come from logic on hclk; strap is a pin
// Notes:   zero-wait ahb-lite slave, register index times four is the address
`timescale 1ns/1ps
`include "phy_pm_map.svh"
module phy_pm_ctrl #(
   parameter bit rmii_variant     = 1'b1,
   parameter int link_pulse_cycles = (`LINK_PULSE_US * 1000) / `CLK_PERIOD_NS
) (
   input  wire logic                          hclk,
   input  wire logic                          hresetn,
   input  wire logic                          hsel,
   input  wire logic [31:0]                   haddr,
   input  wire logic [1:0]                    htrans,
   input  wire logic                          hwrite,
   input  wire logic [2:0]                    hsize,
   input  wire logic [31:0]                   hwdata,
   input  wire logic                          hready,
   output logic      [31:0]                   hrdata,
   output logic                               hreadyout,
   output logic                               hresp,
   input  wire logic                          link_up,
   input  wire logic                          diag_done,
   input  wire logic [`DIAG_RESULT_W-1:0]     diag_count,
   input  wire logic                          nand_tree_strap_n,
   input  wire logic [`NAND_TREE_INPUTS-1:0]  nand_pins,
   output logic                               txd1_o,
   output logic                               txd1_oe,
   output logic                               rx_blocks_on,
   output logic                               tx_on,
   output logic                               energy_detect_on,
   output logic                               pll_on,
   output logic                               core_enable,
   output logic                               crystal_input_enable,
   output logic                               slow_osc_select,
   output logic                               link_pulse_req,
   output logic                               auto_mdix_enable,
   output logic                               mdix_select,
   output logic                               diag_start,
   output logic                               soft_reset_pulse
);
   import phy_pm_pkg::*;

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   function automatic logic idx_mapped(input logic [4:0] idx);
      case (idx)
         `IDX_BASIC_CTRL, `IDX_CTRL_PLL, `IDX_CTRL_OSC, `IDX_CTRL_TEST,
         `IDX_CTRL_ENERGY_DETECT_POWERDOWN, `IDX_POWER_STATUS, `IDX_DIAG, `IDX_CTRL2: idx_mapped = 1'b1;
         default: idx_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic addr_hit(input logic [31:0] a);
      addr_hit = (a[31:7] == 25'h0) && (a[1:0] == 2'b00) && idx_mapped(a[6:2]);
   endfunction

   reg16_t      basic_ctrl_reg;
   reg16_t      ctrl_pll_reg;
   reg16_t      ctrl_osc_reg;
   reg16_t      ctrl_test_reg;
   reg16_t      ctrl_energy_detect_powerdown_reg;
   reg16_t      ctrl2_reg;
   reg16_t      power_status;
   reg16_t      diag_status;
   logic [`DIAG_RESULT_W-1:0] diag_result_reg;
   diag_state_t diag_state_reg;
   logic        wr_pend_reg;
   logic [4:0]  wr_idx_reg;
   logic        addr_phase;
   logic        wr_now;
   reg16_t      wdata;
   logic        strap_s1_reg;
   logic        strap_s2_reg;
   logic        strap_s3_reg;
   logic        strap_caught_reg;
   logic        strap_mode_reg;
   logic        nand_mode;
   logic        an_enabled;
   logic        psave_active;
   logic        energy_detect_powerdown_active;
   logic        powerdown;
   logic [31:0] pulse_cnt_reg;
   logic        diag_go;

   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign addr_phase = hsel && htrans[1] && hready;
   assign wr_now     = wr_pend_reg;
   assign wdata      = hwdata[15:0];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= 5'h00;
      end else begin
         wr_pend_reg <= addr_phase && hwrite && addr_hit(haddr);
         wr_idx_reg  <= haddr[6:2];
      end
   end

   // read data captured in the address phase; the master idles in between
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_phase && !hwrite) begin
         hrdata <= 32'h0000_0000;
         if (addr_hit(haddr)) begin
            case (haddr[6:2])
               `IDX_BASIC_CTRL:   hrdata[15:0] <= basic_ctrl_reg;
               `IDX_CTRL_PLL:     hrdata[15:0] <= ctrl_pll_reg;
               `IDX_CTRL_OSC:     hrdata[15:0] <= ctrl_osc_reg;
               `IDX_CTRL_TEST:    hrdata[15:0] <= ctrl_test_reg;
               `IDX_CTRL_ENERGY_DETECT_POWERDOWN:    hrdata[15:0] <= ctrl_energy_detect_powerdown_reg;
               `IDX_POWER_STATUS: hrdata[15:0] <= power_status;
               `IDX_DIAG:         hrdata[15:0] <= diag_status;
               `IDX_CTRL2:        hrdata[15:0] <= ctrl2_reg;
               default:           hrdata[15:0] <= 16'h0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------------
   // software reset returns every control register to its power-up value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         basic_ctrl_reg <= `RST_BASIC_CTRL;
         ctrl_pll_reg   <= `RST_CTRL_PLL;
         ctrl_osc_reg   <= `RST_CTRL_OSC;
         ctrl_test_reg  <= `RST_CTRL_TEST;
         ctrl_energy_detect_powerdown_reg  <= `RST_CTRL_ENERGY_DETECT_POWERDOWN;
         ctrl2_reg      <= `RST_CTRL2;
      end else if (wr_now && wr_idx_reg == `IDX_BASIC_CTRL && wdata[`BC_SWRESET_BIT]) begin
         basic_ctrl_reg <= `RST_BASIC_CTRL;
         ctrl_pll_reg   <= `RST_CTRL_PLL;
         ctrl_osc_reg   <= `RST_CTRL_OSC;
         ctrl_test_reg  <= `RST_CTRL_TEST;
         ctrl_energy_detect_powerdown_reg  <= `RST_CTRL_ENERGY_DETECT_POWERDOWN;
         ctrl2_reg      <= `RST_CTRL2;
      end else if (wr_now) begin
         case (wr_idx_reg)
            `IDX_BASIC_CTRL: basic_ctrl_reg <= wdata & 16'h7FFF;
            `IDX_CTRL_PLL:   ctrl_pll_reg   <= wdata;
            `IDX_CTRL_OSC:   ctrl_osc_reg   <= wdata;
            `IDX_CTRL_TEST:  ctrl_test_reg  <= wdata;
            `IDX_CTRL_ENERGY_DETECT_POWERDOWN:  ctrl_energy_detect_powerdown_reg  <= wdata;
            `IDX_CTRL2:      ctrl2_reg      <= wdata;
            default:         ctrl2_reg      <= ctrl2_reg;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= wr_now && wr_idx_reg == `IDX_BASIC_CTRL
                             && wdata[`BC_SWRESET_BIT];
      end
   end

   // ----------------------------------------------------------------------
   // nand tree mode
   // ----------------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_s1_reg <= 1'b0;
         strap_s2_reg <= 1'b1;
         strap_s3_reg <= 1'b0;
      end else begin
         strap_s1_reg <= nand_tree_strap_n;
         strap_s2_reg <= strap_s1_reg;
         strap_s3_reg <= strap_s2_reg;
      end
   end

   // caught once stages 2 and 3 agree; their reset values differ so the pin is seen first
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         strap_caught_reg <= 1'b0;
         strap_mode_reg   <= 1'b0;
      end else if (!strap_caught_reg && strap_s2_reg == strap_s3_reg) begin
         strap_caught_reg <= 1'b1;
         strap_mode_reg   <= ~strap_s2_reg;
      end
   end

   assign nand_mode = strap_mode_reg || ctrl_test_reg[`TEST_NAND_BIT];

   nand_tree_if nt_bus ();
   assign nt_bus.pin_level = nand_pins;

   nand_tree_chain #(
      .rmii_variant (rmii_variant)
   ) u_chain (
      .nt (nt_bus.tree)
   );

   // no flop here: the tree must work while ref_clk is a test input
   assign txd1_o  = nand_mode ? nt_bus.chain_out : 1'b0;
   assign txd1_oe = nand_mode;

   // ----------------------------------------------------------------------
   // power modes
   // ----------------------------------------------------------------------
   assign an_enabled   = basic_ctrl_reg[`BC_ANEN_BIT];
   assign powerdown    = basic_ctrl_reg[`BC_PWRDN_BIT];
   assign psave_active = ctrl2_reg[`C2_PSAVE_BIT] && an_enabled && !link_up;
   assign energy_detect_powerdown_active  = !ctrl_energy_detect_powerdown_reg[`ENERGY_DETECT_POWERDOWN_EN_N_BIT] && an_enabled && !link_up;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_blocks_on         <= 1'b0;
         tx_on                <= 1'b0;
         energy_detect_on     <= 1'b0;
         pll_on               <= 1'b0;
         core_enable          <= 1'b0;
         crystal_input_enable <= 1'b1;
         slow_osc_select      <= 1'b0;
      end else begin
         core_enable          <= !powerdown;
         rx_blocks_on         <= !powerdown && !psave_active && !energy_detect_powerdown_active;
         tx_on                <= !powerdown;
         energy_detect_on     <= !powerdown;
         pll_on               <= !powerdown
                                 && !(energy_detect_powerdown_active && ctrl_pll_reg[`PLL_AUTO_OFF_BIT]);
         crystal_input_enable <= !ctrl_osc_reg[`OSC_SLOW_BIT];
         slow_osc_select      <= ctrl_osc_reg[`OSC_SLOW_BIT];
      end
   end

   // link pulses keep coming in energy-detect power-down so two idle ends wake
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pulse_cnt_reg  <= 32'h0000_0000;
         link_pulse_req <= 1'b0;
      end else if (energy_detect_powerdown_active && !powerdown) begin
         link_pulse_req <= (pulse_cnt_reg == 32'(link_pulse_cycles - 1));
         pulse_cnt_reg  <= (pulse_cnt_reg == 32'(link_pulse_cycles - 1))
                           ? 32'h0000_0000 : pulse_cnt_reg + 32'h0000_0001;
      end else begin
         pulse_cnt_reg  <= 32'h0000_0000;
         link_pulse_req <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         auto_mdix_enable <= 1'b1;
         mdix_select      <= 1'b0;
      end else begin
         auto_mdix_enable <= !ctrl2_reg[`C2_MDIX_DIS_BIT];
         mdix_select      <= ctrl2_reg[`C2_MDIX_SEL_BIT];
      end
   end

   assign power_status = {9'h000, link_up, nand_mode, slow_osc_select, powerdown,
                          !pll_on, energy_detect_powerdown_active, psave_active};

   // ----------------------------------------------------------------------
   // cable diagnostic
   // ----------------------------------------------------------------------
   // a start is taken only with crossover disabled, so the pair is fixed
   assign diag_go = wr_now && wr_idx_reg == `IDX_DIAG && wdata[`DIAG_START_BIT]
                    && ctrl2_reg[`C2_MDIX_DIS_BIT] && !powerdown;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diag_state_reg  <= DIAG_IDLE;
         diag_start      <= 1'b0;
         diag_result_reg <= '0;
      end else begin
         diag_start <= 1'b0;
         case (diag_state_reg)
            DIAG_IDLE: begin
               if (diag_go) begin
                  diag_start     <= 1'b1;
                  diag_state_reg <= DIAG_RUN;
               end
            end
            DIAG_RUN: begin
               if (diag_done) begin
                  diag_result_reg <= diag_count;
                  diag_state_reg  <= DIAG_IDLE;
               end
            end
            default: diag_state_reg <= DIAG_IDLE;
         endcase
      end
   end

   assign diag_status = {(diag_state_reg == DIAG_RUN), 6'h00, diag_result_reg};

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   sequence diag_req_s;
      diag_go && diag_state_reg == DIAG_IDLE;
   endsequence

   sequence diag_launch_s;
      diag_start ##1 (diag_state_reg == DIAG_RUN && diag_status[15]);
   endsequence

   nand_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
      txd1_oe == nand_mode && (!nand_mode || txd1_o == nt_bus.chain_out))
      else $error("txd1 drive does not follow nand tree mode");
   nand_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
      nand_mode && nand_pins == 11'h7FE |-> !txd1_o)
      else $error("first nand input low did not give low output");
   nand_high_a: assert property (@(posedge hclk) disable iff (!hresetn)
      nand_mode && nand_pins == 11'h7FF |-> txd1_o)
      else $error("nand tree output not high with all inputs high");
   psave_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
      psave_active && !powerdown && !energy_detect_powerdown_active |=> !rx_blocks_on && tx_on && pll_on)
      else $error("power saving left the wrong blocks on");
   psave_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl2_reg[`C2_PSAVE_BIT] && link_up && !powerdown |=> rx_blocks_on)
      else $error("power saving held receivers off with a link");
   pll_auto_a: assert property (@(posedge hclk) disable iff (!hresetn)
      energy_detect_powerdown_active && ctrl_pll_reg[`PLL_AUTO_OFF_BIT] |=> !pll_on && tx_on)
      else $error("pll not stopped in energy-detect power-down");
   pwrdn_a: assert property (@(posedge hclk) disable iff (!hresetn)
      powerdown |=> !core_enable && !tx_on && !rx_blocks_on)
      else $error("power-down left functions running");
   slow_osc_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(ctrl_osc_reg[`OSC_SLOW_BIT]) |=> slow_osc_select && !crystal_input_enable)
      else $error("slow oscillator select missing");
   soft_rst_a: assert property (@(posedge hclk) disable iff (!hresetn)
      soft_reset_pulse |-> !ctrl2_reg[`C2_PSAVE_BIT] && ctrl_energy_detect_powerdown_reg[`ENERGY_DETECT_POWERDOWN_EN_N_BIT])
      else $error("software reset did not restore power defaults");
   diag_go_a: assert property (@(posedge hclk) disable iff (!hresetn)
      diag_req_s |=> diag_launch_s)
      else $error("diagnostic start not issued");
   diag_res_a: assert property (@(posedge hclk) disable iff (!hresetn)
      diag_state_reg == DIAG_RUN && diag_done |=> diag_status[8:0] == $past(diag_count)
      && !diag_status[15])
      else $error("diagnostic result not captured");
   mdix_ctl_a: assert property (@(posedge hclk) disable iff (!hresetn)
      ctrl2_reg[`C2_MDIX_DIS_BIT] |=> !auto_mdix_enable)
      else $error("crossover not disabled");
   pulse_energy_detect_powerdown_a: assert property (@(posedge hclk) disable iff (!hresetn)
      link_pulse_req |-> $past(energy_detect_powerdown_active))
      else $error("link pulse outside energy-detect power-down");
endmodule // phy_pm_ctrl

// ---- dv/board_test_model.sv ----
// Purpose: board-level test logic that walks the nand tree pins
// Assumes: the block is already in nand tree mode when run is called
// Notes:   pins change on a clock edge and are checked before the next one,
//          so a registered chain output would be flagged as faulty
`timescale 1ns/1ps
`include "phy_pm_map.svh"
module board_test_model #(
   parameter int n = `NAND_TREE_INPUTS
) (
   input  wire logic          hclk,
   input  wire logic          txd1_o,
   output logic      [n-1:0]  nand_pins
);
   initial nand_pins = '1;

   // -------------------------------------------------------------------
   // walk: all high, then low one at a time in pin order, keeping earlier lows
   // -------------------------------------------------------------------
   task automatic run(output int faults);
      logic prev;
      faults = 0;
      nand_pins <= '1;
      @(posedge hclk);
      #1;
      prev = txd1_o;
      for (int i = 0; i < n; i++) begin
         @(posedge hclk);
         nand_pins[i] <= 1'b0;
         #1;
         // no toggle, or the wrong direction, marks this pin as faulty
         if (txd1_o === prev || txd1_o !== i[0]) faults++;
         prev = txd1_o;
      end
      nand_pins <= '1;
   endtask
endmodule // board_test_model

// ---- dv/phy_power_and_test_control_tb_top.sv ----
// Purpose: register-driven test of power modes, nand tree and diagnostic start
// Assumes: zero-wait slave, outputs settle within three cycles of a write
// Notes:   link pulse period shortened to 8 cycles
`timescale 1ns/1ps
module phy_power_and_test_control_tb_top;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, link_up = 0, diag_done = 0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = '0;
   logic [8:0]  diag_count = '0;
   logic [10:0] nand_pins;
   logic        hreadyout, hresp, txd1_o, txd1_oe, rx_blocks_on, tx_on, energy_detect_on;
   logic        pll_on, core_enable, crystal_input_enable, slow_osc_select, link_pulse_req;
   logic        auto_mdix_enable, mdix_select, diag_start, soft_reset_pulse;
   int          mismatches = 0, tests_run = 0, cyc = 0, faults;
   logic        seen, strap_n = 1'b1;

   always #2 hclk = ~hclk;

   phy_pm_ctrl #(.link_pulse_cycles(8)) phy_pm_ctrl_i (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .link_up(link_up), .diag_done(diag_done), .diag_count(diag_count),
      .nand_tree_strap_n(strap_n), .nand_pins(nand_pins), .txd1_o(txd1_o), .txd1_oe(txd1_oe),
      .rx_blocks_on(rx_blocks_on), .tx_on(tx_on), .energy_detect_on(energy_detect_on),
      .pll_on(pll_on), .core_enable(core_enable), .crystal_input_enable(crystal_input_enable),
      .slow_osc_select(slow_osc_select), .link_pulse_req(link_pulse_req),
      .auto_mdix_enable(auto_mdix_enable), .mdix_select(mdix_select),
      .diag_start(diag_start), .soft_reset_pulse(soft_reset_pulse));

   board_test_model board_test_model_i (.hclk(hclk), .txd1_o(txd1_o), .nand_pins(nand_pins));

   // -------------------------------------------------------------------
   // bus access and comparison
   // -------------------------------------------------------------------
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h00_0000, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t: word %h expected %h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t: bit %b expected %b", $time, g, e);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
      chk1(hresp, 1'b0);
   endtask
   task automatic settle;
      repeat (3) @(posedge hclk);
   endtask
   // a pulse is looked for within a bounded window, never waited on forever
   task automatic watch(ref logic s, input int n);
      seen = 1'b0;
      repeat (n) @(posedge hclk) if (s === 1'b1) seen = 1'b1;
   endtask
   task automatic test_done;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         test_done;
      end
   end

   // -------------------------------------------------------------------
   // test sequence
   // -------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rdc(8'h00, 32'h0000_1000);
      rdc(8'h60, 32'h0000_0800);
      rdc(8'h7c, 32'h0000_0000);
      rdc(8'h30, 32'h0000_0000);
      $display("reset values done");
      ahb(1'b1, 8'h7c, 32'h0000_0400);
      settle;
      chk({rx_blocks_on, tx_on, energy_detect_on, pll_on}, 32'h0000_0007);
      rdc(8'h64, 32'h0000_0001);
      link_up <= 1'b1;
      settle;
      chk1(rx_blocks_on, 1'b1);
      ahb(1'b1, 8'h7c, 32'h0000_0000);
      link_up <= 1'b0;
      $display("power saving done");
      ahb(1'b1, 8'h60, 32'h0000_0000);
      ahb(1'b1, 8'h40, 32'h0000_0010);
      settle;
      chk({rx_blocks_on, tx_on, energy_detect_on, pll_on}, 32'h0000_0006);
      rdc(8'h64, 32'h0000_0006);
      watch(link_pulse_req, 20);
      chk1(seen, 1'b1);
      ahb(1'b1, 8'h60, 32'h0000_0800);
      ahb(1'b1, 8'h40, 32'h0000_0000);
      $display("energy detect done");
      ahb(1'b1, 8'h58, 32'h0000_0020);
      settle;
      chk1(txd1_oe, 1'b1);
      chk1(txd1_o, 1'b1);
      board_test_model_i.run(faults);
      chk(faults, 32'h0000_0000);
      ahb(1'b1, 8'h58, 32'h0000_0000);
      settle;
      chk({txd1_oe, txd1_o}, 32'h0000_0000);
      $display("nand tree done");
      // a start with crossover still automatic must be ignored
      fork
         ahb(1'b1, 8'h74, 32'h0000_8000);
         watch(diag_start, 6);
      join
      chk1(seen, 1'b0);
      ahb(1'b1, 8'h7c, 32'h0000_6000);
      settle;
      chk({auto_mdix_enable, mdix_select}, 32'h0000_0001);
      fork
         ahb(1'b1, 8'h74, 32'h0000_8000);
         watch(diag_start, 6);
      join
      chk1(seen, 1'b1);
      rdc(8'h74, 32'h0000_8000);
      @(posedge hclk);
      diag_count <= 9'h1a5;
      diag_done <= 1'b1;
      @(posedge hclk);
      diag_done <= 1'b0;
      rdc(8'h74, 32'h0000_01a5);
      $display("diagnostic done");
      ahb(1'b1, 8'h00, 32'h0000_1800);
      ahb(1'b1, 8'h44, 32'h0000_0020);
      settle;
      chk({core_enable, crystal_input_enable, slow_osc_select}, 32'h0000_0001);
      ahb(1'b1, 8'h44, 32'h0000_0000);
      ahb(1'b1, 8'h00, 32'h0000_1000);
      settle;
      chk({core_enable, crystal_input_enable, slow_osc_select}, 32'h0000_0006);
      fork
         ahb(1'b1, 8'h00, 32'h0000_9000);
         watch(soft_reset_pulse, 6);
      join
      chk1(seen, 1'b1);
      settle;
      rdc(8'h7c, 32'h0000_0000);
      $display("power down exit done");
      // second reset with the strap low: the tree mode must come from the pin
      strap_n <= 1'b0;
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (6) @(posedge hclk);
      chk1(txd1_oe, 1'b1);
      chk1(txd1_o, 1'b1);
      $display("strap done");
      test_done;
   end
endmodule // phy_power_and_test_control_tb_top
